// ---- hw/ssa_pkg.sv ----
// shared constants and types of the serial system-area slave and its bus master
package ssa_pkg;
  // timebase
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned START_TIMEOUT_NS = 35000;
  localparam int unsigned CLK_WIDTH_MAX_NS = 25000;
  localparam int unsigned WRITE_TIME_NS = 5000000;
  localparam int unsigned LINK_PERIOD_NS = 10000;
  // longest times round down
  localparam int unsigned START_TIMEOUT_CYC = START_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned CLK_WIDTH_MAX_CYC = CLK_WIDTH_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned WRITE_TIME_CYC = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LINK_QTR_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // device select
  localparam logic [3:0] DSEL_TYPE = 4'hA;
  localparam logic [1:0] DSEL_LOW_ENABLES = 2'h3;
  // system area byte addresses
  localparam logic [15:0] ADDR_HOST_PW = 16'h0900;
  localparam logic [15:0] ADDR_RADIO_PW1 = 16'h0904;
  localparam logic [15:0] ADDR_RADIO_PW2 = 16'h0908;
  localparam logic [15:0] ADDR_RADIO_PW3 = 16'h090C;
  localparam logic [15:0] ADDR_CFG = 16'h0910;
  localparam logic [15:0] ADDR_REV = 16'h0911;
  localparam logic [15:0] ADDR_AFI = 16'h0912;
  localparam logic [15:0] ADDR_STORAGE_FORMAT_ID = 16'h0913;
  localparam logic [15:0] ADDR_UID = 16'h0914;
  localparam logic [15:0] ADDR_SIZE_REF = 16'h091C;
  localparam logic [15:0] ADDR_CTRL = 16'h0920;
  // reset values
  localparam logic [31:0] PW_RESET = 32'h0000_0000;
  localparam logic [7:0] CFG_RESET = 8'hF4;
  localparam logic [7:0] AFI_VALUE = 8'h00;
  localparam logic [7:0] STORAGE_FORMAT_ID_VALUE = 8'hFF;
  // configuration byte fields
  localparam int unsigned CFG_SINK_LO = 0;
  localparam int unsigned CFG_SINK_HI = 1;
  localparam int unsigned CFG_HARV_DEFAULT = 2;
  localparam int unsigned CFG_ACTIVITY_PIN = 3;
  // control register field
  localparam int unsigned CTRL_HARV = 0;
  // host register offsets on apb
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_TXD = 8'h04;
  localparam logic [7:0] HREG_STATUS = 8'h08;
  localparam logic [7:0] HREG_RXD = 8'h0C;
  localparam int unsigned CMD_NACK = 2;
  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_STOP = 2'b01,
    CMD_WRITE = 2'b10,
    CMD_READ = 2'b11
  } ssa_cmd_t;
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_RECV = 3'b001,
    DS_ACK = 3'b010,
    DS_SEND = 3'b011,
    DS_MACK = 3'b100,
    DS_WCYC = 3'b101
  } ssa_dev_state_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BYTE = 2'b10,
    HS_STOP = 2'b11
  } ssa_host_state_t;
endpackage

// ---- hw/ssa_link_if.sv ----
// two-wire link between bus master and slave, open-drain wires resolved here
`timescale 1ns/1ps
`default_nettype none
interface ssa_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  wire scl;
  wire sda;
  // pull-up wins unless an enabled driver pulls low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
  modport master (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe,
                  input scl, input sda);
  modport device (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// ---- hw/ssa_sync.sv ----
// two-flop synchroniser for pins entering the clk domain
`timescale 1ns/1ps
`default_nettype none
module ssa_sync #(
  parameter int unsigned W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import ssa_pkg::*;
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssa_sync_t;
  ssa_sync_t s;
  ssa_sync_t next_s;
  always_comb begin
    next_s.s1 = din;
    next_s.s2 = s.s1;
  end
  // idle bus level is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end
  assign dout = s.s2;
endmodule
`default_nettype wire

// ---- hw/ssa_device.sv ----
// serial slave front end with system parameter area
//
// Chosen here: the two-wire link as the only register port.
`timescale 1ns/1ps
`default_nettype none
module ssa_device #(
  parameter int unsigned START_CYC = ssa_pkg::START_TIMEOUT_CYC,
  parameter int unsigned CLKMAX_CYC = ssa_pkg::CLK_WIDTH_MAX_CYC,
  parameter int unsigned WRITE_CYC = ssa_pkg::WRITE_TIME_CYC,
  // arbitrary identity values
  parameter logic [3:0] REVISION = 4'h5,
  parameter logic [63:0] UNIQUE_ID = 64'h1122_3344_5566_7788,
  parameter logic [31:0] SIZE_REF = 32'h0001_0203
) (
  input wire logic clk,
  input wire logic rst_n,
  ssa_link_if.device link,
  input wire logic field_on,
  output logic harvest_enable,
  output logic sink_level_hi,
  output logic sink_level_lo,
  output logic harvest_default,
  output logic radio_activity_pin,
  output logic radio_comm_block,
  output logic write_cycle,
  output logic write_unlocked,
  output logic [7:0] radio_control_view
);
  import ssa_pkg::*;
  typedef struct packed {
    ssa_dev_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] bno;
    logic rw;
    logic nack;
    logic first;
    logic drv;
    logic wr_pend;
    logic cfg_pend;
    logic pw_pend;
    logic [15:0] addr;
    logic [31:0] tmr;
    logic [7:0] cfg;
    logic [7:0] cfg_buf;
    logic [31:0] pw;
    logic [31:0] pw_buf;
    logic pw_ok;
    logic harv;
    logic tprog;
    logic scl_q;
    logic sda_q;
  } ssa_dev_t;
  ssa_dev_t s;
  ssa_dev_t next_s;
  logic [2:0] pins;
  logic scl_s;
  logic sda_s;
  logic field_s;

  ssa_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({field_on, link.sda, link.scl}),
    .dout(pins)
  );
  assign scl_s = pins[0];
  assign sda_s = pins[1];
  assign field_s = pins[2];

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic ack;
    logic [7:0] rd;
    logic [15:0] off;
    rise = ~s.scl_q & scl_s;
    fall = s.scl_q & ~scl_s;
    start = s.scl_q & scl_s & s.sda_q & ~sda_s;
    stop = s.scl_q & scl_s & ~s.sda_q & sda_s;
    ack = 1'b1;
    off = s.addr - ADDR_UID;
    // read mux for the byte at the address counter
    rd = 8'hFF;
    if (s.addr[15:2] == ADDR_HOST_PW[15:2]) begin
      rd = s.pw[{s.addr[1:0], 3'b000} +: 8];
    end else if (s.addr >= ADDR_RADIO_PW1 && s.addr < ADDR_CFG) begin
      rd = 8'h00;
    end else if (s.addr == ADDR_CFG) begin
      rd = s.cfg;
    end else if (s.addr == ADDR_REV) begin
      rd = {REVISION, 4'h0};
    end else if (s.addr == ADDR_AFI) begin
      rd = AFI_VALUE;
    end else if (s.addr == ADDR_STORAGE_FORMAT_ID) begin
      rd = STORAGE_FORMAT_ID_VALUE;
    end else if (s.addr >= ADDR_UID && s.addr < ADDR_SIZE_REF) begin
      rd = UNIQUE_ID[{off[2:0], 3'b000} +: 8];
    end else if (s.addr >= ADDR_SIZE_REF && s.addr < ADDR_CTRL) begin
      rd = SIZE_REF[{s.addr[1:0], 3'b000} +: 8];
    end else if (s.addr == ADDR_CTRL) begin
      rd = {s.tprog, 5'h00, field_s, s.harv};
    end
    next_s = s;
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;
    if (s.tmr != 32'hFFFF_FFFF) begin
      next_s.tmr = s.tmr + 32'h1;
    end
    // before the first bit only the start timeout runs
    // bus traffic must not stretch the write cycle
    if ((rise | fall) & ~s.first & (s.st != DS_WCYC)) begin
      next_s.tmr = '0;
    end
    case (s.st)
      DS_RECV: begin
        if (rise) begin
          next_s.sh = {s.sh[6:0], sda_s};
          next_s.cnt = s.cnt + 4'h1;
          next_s.first = 1'b0;
          next_s.tmr = '0;
        end else if (fall && s.cnt == 4'h8) begin
          next_s.cnt = '0;
          if (s.bno == 2'd0) begin
            ack = s.sh[7:4] == DSEL_TYPE && s.sh[3] && s.sh[2:1] == DSEL_LOW_ENABLES;
            next_s.rw = s.sh[0];
          end else if (s.bno == 2'd1) begin
            next_s.addr[15:8] = s.sh;
          end else if (s.bno == 2'd2) begin
            next_s.addr[7:0] = s.sh;
          end else begin
            next_s.addr = s.addr + 16'h1;
            if (s.addr[15:2] == ADDR_HOST_PW[15:2]) begin
              next_s.pw_buf[{s.addr[1:0], 3'b000} +: 8] = s.sh;
              next_s.pw_pend = 1'b1;
            end else if (s.addr == ADDR_CFG) begin
              next_s.cfg_buf = s.sh;
              next_s.cfg_pend = 1'b1;
            end else if (s.addr == ADDR_CTRL) begin
              next_s.harv = s.sh[CTRL_HARV];
            end else if (s.addr > ADDR_CFG && s.addr < ADDR_CTRL) begin
              ack = 1'b1;
            end else begin
              ack = 1'b0;
            end
            next_s.wr_pend = s.wr_pend | ack;
          end
          if (s.bno != 2'd3) begin
            next_s.bno = s.bno + 2'd1;
          end
          next_s.st = ack ? DS_ACK : DS_IDLE;
          next_s.drv = ack;
        end
      end
      DS_ACK: begin
        if (fall) begin
          next_s.drv = 1'b0;
          if (s.rw && s.bno == 2'd1) begin
            next_s.st = DS_SEND;
            next_s.sh = rd;
            next_s.drv = ~rd[7];
            next_s.addr = s.addr + 16'h1;
          end else begin
            next_s.st = DS_RECV;
          end
        end
      end
      DS_SEND: begin
        if (rise) begin
          next_s.cnt = s.cnt + 4'h1;
        end else if (fall) begin
          if (s.cnt == 4'h8) begin
            next_s.cnt = '0;
            next_s.drv = 1'b0;
            next_s.st = DS_MACK;
          end else begin
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.drv = ~s.sh[6];
          end
        end
      end
      DS_MACK: begin
        if (rise) begin
          next_s.nack = sda_s;
        end else if (fall) begin
          if (s.nack) begin
            next_s.st = DS_IDLE;
          end else begin
            next_s.st = DS_SEND;
            next_s.sh = rd;
            next_s.drv = ~rd[7];
            next_s.addr = s.addr + 16'h1;
          end
        end
      end
      DS_WCYC: begin
        next_s.drv = 1'b0;
        if (s.tmr >= WRITE_CYC) begin
          next_s.st = DS_IDLE;
          next_s.tprog = 1'b1;
          if (s.cfg_pend) begin
            next_s.cfg = s.cfg_buf;
          end
          if (s.pw_pend) begin
            if (s.pw_ok) begin
              next_s.pw = s.pw_buf;
            end else begin
              next_s.pw_ok = s.pw_buf == s.pw;
            end
          end
          next_s.cfg_pend = 1'b0;
          next_s.pw_pend = 1'b0;
        end
      end
      default: begin
        next_s.drv = 1'b0;
      end
    endcase
    // starts and stops are not seen during the write cycle
    if (s.st != DS_WCYC) begin
      if (start) begin
        next_s.st = DS_RECV;
        next_s.bno = 2'd0;
        next_s.cnt = '0;
        next_s.first = 1'b1;
        next_s.tmr = '0;
        next_s.drv = 1'b0;
        next_s.wr_pend = 1'b0;
        next_s.cfg_pend = 1'b0;
        next_s.pw_pend = 1'b0;
      end else if (stop) begin
        // the stop's own scl rise counted one bit of the next byte
        if (s.st == DS_RECV && s.cnt == 4'h1 && s.bno == 2'd3 && s.wr_pend) begin
          next_s.st = DS_WCYC;
          next_s.tprog = 1'b0;
          next_s.tmr = '0;
        end else begin
          next_s.st = DS_IDLE;
        end
        next_s.drv = 1'b0;
      end else if (s.st != DS_IDLE) begin
        if ((s.first && s.tmr >= START_CYC) ||
            (!s.first && s.tmr >= CLKMAX_CYC)) begin
          next_s.st = DS_IDLE;
          next_s.drv = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= DS_IDLE;
      s.cfg <= CFG_RESET;
      s.cfg_buf <= CFG_RESET;
      s.pw <= PW_RESET;
      s.pw_buf <= PW_RESET;
      s.harv <= ~CFG_RESET[CFG_HARV_DEFAULT];
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe = s.drv;
  assign harvest_enable = s.harv;
  assign sink_level_hi = s.cfg[CFG_SINK_HI];
  assign sink_level_lo = s.cfg[CFG_SINK_LO];
  assign harvest_default = s.cfg[CFG_HARV_DEFAULT];
  assign radio_activity_pin = s.cfg[CFG_ACTIVITY_PIN];
  assign radio_comm_block = s.st != DS_IDLE;
  assign write_cycle = s.st == DS_WCYC;
  assign write_unlocked = s.pw_ok;
  assign radio_control_view = {1'b0, 5'h00, 1'b1, s.harv};
endmodule
`default_nettype wire

// ---- hw/ssa_host.sv ----
// two-wire bus master commanded over apb
`timescale 1ns/1ps
`default_nettype none
module ssa_host #(
  parameter int unsigned QTR_CYC = ssa_pkg::LINK_QTR_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ssa_link_if.master link
);
  import ssa_pkg::*;
  typedef struct packed {
    ssa_host_state_t st;
    logic [1:0] ph;
    logic [3:0] bcnt;
    logic [15:0] div;
    logic [7:0] sh;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic rd;
    logic nack_out;
    logic ack_seen;
    logic scl_low;
    logic sda_low;
    logic [31:0] prdata;
  } ssa_host_reg_t;
  ssa_host_reg_t s;
  ssa_host_reg_t next_s;
  logic sda_s;
  logic busy;
  logic mapped;

  ssa_sync #(.W(1)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(link.sda),
    .dout(sda_s)
  );
  assign busy = s.st != HS_IDLE;
  assign mapped = paddr == HREG_CMD || paddr == HREG_TXD ||
                  paddr == HREG_STATUS || paddr == HREG_RXD;

  always_comb begin
    logic tick;
    logic wr;
    tick = s.div == 16'(QTR_CYC - 1);
    wr = psel & penable & pwrite;
    next_s = s;
    next_s.div = tick ? '0 : s.div + 16'h1;
    if (!busy) begin
      next_s.div = '0;
    end
    // read data registered in the setup cycle
    if (psel && !penable) begin
      case (paddr)
        HREG_TXD: next_s.prdata = {24'h0, s.txd};
        HREG_STATUS: next_s.prdata = {30'h0, s.ack_seen, busy};
        HREG_RXD: next_s.prdata = {24'h0, s.rxd};
        default: next_s.prdata = '0;
      endcase
    end
    if (wr && paddr == HREG_TXD) begin
      next_s.txd = pwdata[7:0];
    end
    // a command written while busy is dropped
    if (wr && paddr == HREG_CMD && !busy) begin
      next_s.ph = 2'd0;
      next_s.bcnt = '0;
      next_s.sh = s.txd;
      next_s.rd = 1'b0;
      next_s.nack_out = pwdata[CMD_NACK];
      case (ssa_cmd_t'(pwdata[1:0]))
        CMD_START: next_s.st = HS_START;
        CMD_STOP: next_s.st = HS_STOP;
        CMD_WRITE: next_s.st = HS_BYTE;
        CMD_READ: begin
          next_s.st = HS_BYTE;
          next_s.rd = 1'b1;
        end
        default: next_s.st = HS_IDLE;
      endcase
    end
    if (busy && tick) begin
      next_s.ph = s.ph + 2'd1;
      case (s.st)
        HS_START: begin
          if (s.ph == 2'd0) next_s.sda_low = 1'b0;
          if (s.ph == 2'd1) next_s.scl_low = 1'b0;
          if (s.ph == 2'd2) next_s.sda_low = 1'b1;
          if (s.ph == 2'd3) begin
            next_s.scl_low = 1'b1;
            next_s.st = HS_IDLE;
          end
        end
        HS_STOP: begin
          if (s.ph == 2'd0) begin
            next_s.scl_low = 1'b1;
            next_s.sda_low = 1'b1;
          end
          if (s.ph == 2'd1) next_s.scl_low = 1'b0;
          if (s.ph == 2'd2) next_s.sda_low = 1'b0;
          if (s.ph == 2'd3) next_s.st = HS_IDLE;
        end
        HS_BYTE: begin
          if (s.ph == 2'd0) begin
            // data changes only with scl low
            next_s.scl_low = 1'b1;
            if (s.bcnt < 4'd8) begin
              next_s.sda_low = s.rd ? 1'b0 : ~s.sh[7];
            end else begin
              next_s.sda_low = s.rd ? ~s.nack_out : 1'b0;
            end
          end
          if (s.ph == 2'd1) next_s.scl_low = 1'b0;
          if (s.ph == 2'd2) begin
            if (s.bcnt < 4'd8 && s.rd) begin
              next_s.rxd = {s.rxd[6:0], sda_s};
            end else if (s.bcnt == 4'd8 && !s.rd) begin
              next_s.ack_seen = ~sda_s;
            end
          end
          if (s.ph == 2'd3) begin
            next_s.scl_low = 1'b1;
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.bcnt = s.bcnt + 4'h1;
            if (s.bcnt == 4'd8) begin
              next_s.st = HS_IDLE;
              next_s.sda_low = 1'b0;
            end
          end
        end
        default: next_s.st = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= HS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign link.scl_o = 1'b0;
  assign link.scl_oe = s.scl_low;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = s.sda_low;
endmodule
`default_nettype wire

// ---- verification/ssa_link_assertions.sv ----
// checker for the two-wire link between the bus master and the slave
`timescale 1ns/1ps
`default_nettype none
module ssa_link_checker #(
  parameter int unsigned WRITE_CYC = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic write_cycle,
  input wire logic radio_comm_block
);
  logic active;
  logic prev_scl;
  logic prev_sda;
  logic [31:0] wc_cnt;
  // start and stop seen at the pins one cycle late, device reacts later still
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
      wc_cnt <= 32'h0;
    end else begin
      prev_scl <= scl;
      prev_sda <= sda;
      if (prev_scl && scl && prev_sda && !sda)
        active <= 1'b1;
      else if (prev_scl && scl && !prev_sda && sda)
        active <= 1'b0;
      wc_cnt <= write_cycle ? wc_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_open_drain;
    !d_sda_o && !scl_o && !m_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("link driver drives high");
  property p_scl_master;
    !scl |-> scl_oe;
  endproperty
  a_scl_master: assert property (p_scl_master) else $error("clock low without master");
  property p_dev_after_start;
    d_sda_oe |-> active;
  endproperty
  a_dev_after_start: assert property (p_dev_after_start) else $error("slave drives idle bus");
  property p_dev_scl_low;
    $changed(d_sda_oe) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low) else $error("slave data moved, clock high");
  property p_wcyc_quiet;
    write_cycle |-> !d_sda_oe;
  endproperty
  a_wcyc_quiet: assert property (p_wcyc_quiet) else $error("slave drives in write cycle");
  property p_wcyc_after_stop;
    $rose(write_cycle) |-> !active && scl && sda;
  endproperty
  a_wcyc_after_stop: assert property (p_wcyc_after_stop) else $error("write cycle not after stop");
  // tolerance of one cycle for the register stage of the flag
  property p_wcyc_len;
    $fell(write_cycle) |-> (wc_cnt >= WRITE_CYC - 1) && (wc_cnt <= WRITE_CYC + 1);
  endproperty
  a_wcyc_len: assert property (p_wcyc_len) else $error("write cycle length wrong");
  property p_radio_block;
    ((prev_scl && scl && prev_sda && !sda) || write_cycle || d_sda_oe)
      |-> ##[0:4] radio_comm_block;
  endproperty
  a_radio_block: assert property (p_radio_block) else $error("radio not blocked");
  c_ack: cover property (d_sda_oe && scl);
  c_wcyc: cover property ($rose(write_cycle));
  c_stop: cover property ($fell(active));
endmodule
`default_nettype wire

// ---- verification/ssa_bench.sv ----
// self-checking bench: apb-driven master against the system-area slave
`timescale 1ns/1ps
`default_nettype none
module ssa_bench;
  import ssa_pkg::*;
  localparam int unsigned WCYC = 400;
  // arbitrary identity values
  localparam logic [3:0] REV = 4'h9;
  localparam logic [63:0] UNIQUE_IDENTIFIER = 64'h0F1E_2D3C_4B5A_6978;
  localparam logic [31:0] SREF = 32'h0A0B_0C0D;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic field_on = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, harv, s_hi, s_lo, h_def, act_pin, rblock, wcyc, unl;
  logic [7:0] rview;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] pw = 32'h0;
  logic [7:0] cfg = 8'hF4;
  logic tprog = 1'b0;
  logic hv = 1'b0;
  always #12.5 clk = ~clk;
  ssa_link_if link();
  ssa_host #(.QTR_CYC(4)) ssa_host_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  ssa_device #(.WRITE_CYC(WCYC), .REVISION(REV), .UNIQUE_ID(UNIQUE_IDENTIFIER), .SIZE_REF(SREF))
    ssa_device_i (.clk(clk), .rst_n(rst_n), .link(link), .field_on(field_on),
    .harvest_enable(harv), .sink_level_hi(s_hi), .sink_level_lo(s_lo),
    .harvest_default(h_def), .radio_activity_pin(act_pin), .radio_comm_block(rblock),
    .write_cycle(wcyc), .write_unlocked(unl), .radio_control_view(rview));
  ssa_link_checker #(.WRITE_CYC(WCYC)) ssa_link_checker_i (.clk(clk), .rst_n(rst_n),
    .scl_o(link.scl_o), .scl_oe(link.scl_oe), .m_sda_o(link.m_sda_o),
    .m_sda_oe(link.m_sda_oe), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
    .scl(link.scl), .sda(link.sda), .write_cycle(wcyc), .radio_comm_block(rblock));
  task automatic finish_test();
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // a command written while busy is dropped, so each command polls status until idle
  task automatic cmd(input logic [2:0] c);
    logic [31:0] r;
    logic e;
    apb(1'b1, HREG_CMD, 32'(c), r, e);
    do apb(1'b0, HREG_STATUS, 32'h0, r, e); while (r[0] !== 1'b0);
  endtask
  task automatic wb(input logic [7:0] b, input logic ea);
    logic [31:0] r;
    logic e;
    apb(1'b1, HREG_TXD, 32'(b), r, e);
    cmd({1'b0, CMD_WRITE});
    apb(1'b0, HREG_STATUS, 32'h0, r, e);
    chk("ack", 32'(ea), 32'(r[1]));
  endtask
  task automatic sel(input logic [15:0] a, input logic rdn);
    cmd({1'b0, CMD_START});
    wb(8'hAE, 1'b1);
    wb(a[15:8], 1'b1);
    wb(a[7:0], 1'b1);
    if (rdn) begin
      cmd({1'b0, CMD_START});
      wb(8'hAF, 1'b1);
    end
  endtask
  // acked writes also probe the bus while the write cycle runs
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input int n, input logic ea);
    sel(a, 1'b0);
    for (int i = 0; i < n; i++) wb(d[8*i+:8], ea);
    cmd({1'b0, CMD_STOP});
    if (ea) begin
      chk("write cycle", 32'h1, 32'(wcyc));
      cmd({1'b0, CMD_START});
      wb(8'hAE, 1'b0);
      cmd({1'b0, CMD_STOP});
      tprog = 1'b1;
    end
    while (wcyc === 1'b1) @(posedge clk);
  endtask
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    if (a < ADDR_RADIO_PW1) return pw[8*(a-ADDR_HOST_PW)+:8];
    if (a < ADDR_CFG) return 8'h00;
    if (a == ADDR_CFG) return cfg;
    if (a == ADDR_REV) return {REV, 4'h0};
    if (a == ADDR_AFI) return 8'h00;
    if (a == ADDR_STORAGE_FORMAT_ID) return 8'hFF;
    if (a < ADDR_SIZE_REF) return UNIQUE_IDENTIFIER[8*(a-ADDR_UID)+:8];
    if (a < ADDR_CTRL) return SREF[8*(a-ADDR_SIZE_REF)+:8];
    return {tprog, 5'h00, field_on, hv};
  endfunction
  task automatic rd_seq(input logic [15:0] a, input int n);
    logic [7:0] b;
    sel(a, 1'b1);
    chk("radio block", 32'h1, 32'(rblock));
    for (int i = 0; i < n; i++) begin
      rb_one(i == n - 1, b);
      chk("read byte", 32'(exp_byte(a + 16'(i))), 32'(b));
    end
    cmd({1'b0, CMD_STOP});
    chk("radio free", 32'h0, 32'(rblock));
  endtask
  task automatic rb_one(input logic nack, output logic [7:0] b);
    logic [31:0] r;
    logic e;
    cmd({nack, CMD_READ});
    apb(1'b0, HREG_RXD, 32'h0, r, e);
    chk("rxd err", 32'h0, 32'(e));
    b = r[7:0];
  endtask
  // the master parks with scl low, so both limits can be reached
  task automatic t_timeout();
    cmd({1'b0, CMD_START});
    chk("radio block", 32'h1, 32'(rblock));
    repeat (START_TIMEOUT_CYC + 16) @(posedge clk);
    chk("start timeout", 32'h0, 32'(rblock));
    cmd({1'b0, CMD_START});
    wb(8'hAE, 1'b1);
    repeat (CLK_WIDTH_MAX_CYC + 16) @(posedge clk);
    chk("clock timeout", 32'h0, 32'(rblock));
    wb(8'hAE, 1'b0);
    cmd({1'b0, CMD_STOP});
  endtask
  task automatic t_power_on();
    chk("unlocked", 32'h0, 32'(unl));
    chk("cfg pins", 32'h2, 32'({s_hi, s_lo, h_def, act_pin}));
    chk("harvest", 32'h0, 32'(harv));
    rd_seq(ADDR_HOST_PW, 33);
  endtask
  task automatic t_select();
    logic [31:0] r;
    logic e;
    cmd({1'b0, CMD_START});
    wb(8'hA6, 1'b0);
    cmd({1'b0, CMD_START});
    wb(8'h9E, 1'b0);
    cmd({1'b0, CMD_STOP});
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
  endtask
  task automatic t_config();
    wr(ADDR_AFI, 32'h5A, 1, 1'b1);
    wr(ADDR_RADIO_PW2, 32'h77, 1, 1'b0);
    wr(ADDR_CFG, 32'hFB, 1, 1'b1);
    cfg = 8'hFB;
    chk("cfg pins", 32'hD, 32'({s_hi, s_lo, h_def, act_pin}));
    rd_seq(ADDR_RADIO_PW3, 8);
  endtask
  task automatic t_password();
    wr(ADDR_HOST_PW, 32'h0000_0001, 4, 1'b1);
    chk("unlocked", 32'h0, 32'(unl));
    wr(ADDR_HOST_PW, 32'h0000_0000, 4, 1'b1);
    chk("unlocked", 32'h1, 32'(unl));
    wr(ADDR_HOST_PW, 32'hC3A5_5A3C, 4, 1'b1);
    pw = 32'hC3A5_5A3C;
    rd_seq(ADDR_HOST_PW, 4);
  endtask
  task automatic t_control();
    field_on <= 1'b0;
    wr(ADDR_CTRL, 32'hFF, 1, 1'b1);
    hv = 1'b1;
    chk("harvest", 32'h1, 32'(harv));
    chk("radio view", 32'h03, 32'(rview));
    rd_seq(ADDR_CTRL, 1);
  endtask
  initial begin
    #2_000_000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_power_on();
    t_select();
    t_config();
    t_password();
    t_control();
    t_timeout();
    finish_test();
  end
endmodule
`default_nettype wire
